// >>> hw/fault_detect_shutdown.sv
/*
  Fault detection and shutdown block with APB register access.
  Assumes fault request lines are levels; the external pin and the debug
  mode indicator are asynchronous and are synchronised here.
*/
// How it works
// - Eight fault inputs and eight pin channels, each configured on its own.
// - Inputs 0..7: keyboard, comp0, comp1, timer0, timer1, pwt ready, pin, debug.
// - Outputs 0..3 port C, 4..5 port B, 6..7 port A timer pins.
// - The block detects faults and overrides pins only while its enable bit is set; the interrupt request follows the flag.
// - Each input has its own enable; only enabled inputs record faults.
// - A fault on an enabled input latches its bit and sets the flag.
// - Interrupt enable gates the fault flag onto the interrupt request.
// - Writing one to force fault makes a software fault.
// - Pin with function enable clear stays in bypass.
// - Enabled pin under fault is forced to its preset state.
// - Direction bit picks driven level or high impedance during fault.
// - Value bit gives the driven level during fault.
// - Pins release only after source gone and flag cleared.
// - Shutdown follows a fault in the same clock; pin and debug inputs first take two sync clocks.
// - Any fault shuts down every configured pin at once.
`timescale 1ns/1ps
module fault_detect_shutdown
  import fault_shutdown_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic keyboard_interrupt,
  input wire logic comparator0_interrupt,
  input wire logic comparator1_interrupt,
  input wire logic modulo_timer0_interrupt,
  input wire logic modulo_timer1_interrupt,
  input wire logic pulse_width_timer_ready,
  input wire logic external_fault_pin,
  input wire logic debug_mode_active,
  input wire logic [3:0] port_c_normal,
  input wire logic [3:0] port_c_normal_oe_n,
  input wire logic [1:0] port_b_normal,
  input wire logic [1:0] port_b_normal_oe_n,
  input wire logic [1:0] port_a_normal,
  input wire logic [1:0] port_a_normal_oe_n,
  output logic [3:0] port_c_out,
  output logic [3:0] port_c_oe_n,
  output logic [1:0] port_b_out,
  output logic [1:0] port_b_oe_n,
  output logic [1:0] port_a_out,
  output logic [1:0] port_a_oe_n,
  output logic fault_irq
);

  // ****************************************************************
  // Input gathering and synchronisers
  // ****************************************************************
  logic [1:0] async_meta_q;
  logic [1:0] async_sync_q;
  logic [7:0] fault_input_channel;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      async_meta_q <= 2'h0;
      async_sync_q <= 2'h0;
    end else begin
      async_meta_q <= {debug_mode_active, external_fault_pin};
      async_sync_q <= async_meta_q;
    end
  end

  assign fault_input_channel = {async_sync_q[1], async_sync_q[0], pulse_width_timer_ready,
                                modulo_timer1_interrupt, modulo_timer0_interrupt,
                                comparator1_interrupt, comparator0_interrupt,
                                keyboard_interrupt};

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [7:0] fault_input_enable_q;
  logic [7:0] fault_input_latch_q;
  logic [7:0] fault_input_latch_d;
  logic [7:0] pin_function_enable_q;
  logic [7:0] pin_direction_q;
  logic [7:0] pin_value_q;
  logic fault_flag_q;
  logic fault_flag_d;
  logic fault_irq_enable_q;
  logic block_enable_q;
  logic force_fault_q;
  logic wr_access;
  logic wr_lane0;
  logic addr_mapped;
  logic wr_cs;
  logic flag_clear;
  logic [7:0] cs_read;
  logic [7:0] read_byte;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign wr_lane0 = wr_access && pstrb[0];
  assign addr_mapped = hit(paddr, off_control_status) || hit(paddr, off_input_enable) ||
                       hit(paddr, off_input_latch) || hit(paddr, off_pin_enable) ||
                       hit(paddr, off_pin_direction) || hit(paddr, off_pin_value);
  assign pslverr = psel && penable && !addr_mapped;
  assign wr_cs = wr_lane0 && hit(paddr, off_control_status);
  assign flag_clear = wr_cs && !pwdata[bit_fault_flag];
  assign cs_read = {fault_flag_q, fault_irq_enable_q, block_enable_q, 5'h00};
  assign read_byte = hit(paddr, off_control_status) ? cs_read :
                     hit(paddr, off_input_enable) ? fault_input_enable_q :
                     hit(paddr, off_input_latch) ? fault_input_latch_q :
                     hit(paddr, off_pin_enable) ? pin_function_enable_q :
                     hit(paddr, off_pin_direction) ? pin_direction_q :
                     hit(paddr, off_pin_value) ? pin_value_q : 8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, read_byte};
    end
  end

  // Configuration registers, all clear after reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_input_enable_q <= reset_byte;
      pin_function_enable_q <= reset_byte;
      pin_direction_q <= reset_byte;
      pin_value_q <= reset_byte;
      fault_irq_enable_q <= 1'b0;
      block_enable_q <= 1'b0;
    end else if (wr_lane0) begin
      if (hit(paddr, off_input_enable)) fault_input_enable_q <= pwdata[7:0];
      if (hit(paddr, off_pin_enable)) pin_function_enable_q <= pwdata[7:0];
      if (hit(paddr, off_pin_direction)) pin_direction_q <= pwdata[7:0];
      if (hit(paddr, off_pin_value)) pin_value_q <= pwdata[7:0];
      if (hit(paddr, off_control_status)) begin
        fault_irq_enable_q <= pwdata[bit_fault_irq_enable];
        block_enable_q <= pwdata[bit_block_enable];
      end
    end
  end

  // ****************************************************************
  // Fault detection
  // ****************************************************************
  logic [7:0] enabled_faults;
  logic fault_now;
  logic fault_active;
  logic sw_fault;

  // Software fault persists as a source until the flag is cleared
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      force_fault_q <= 1'b0;
    end else if (wr_cs && pwdata[bit_force_fault] && pwdata[bit_block_enable] &&
                 block_enable_q) begin
      force_fault_q <= 1'b1;
    end else if (flag_clear) begin
      force_fault_q <= 1'b0;
    end
  end

  assign enabled_faults = block_enable_q ? (fault_input_channel & fault_input_enable_q) :
                          8'h00;
  assign sw_fault = block_enable_q && force_fault_q;
  assign fault_now = (|enabled_faults) || sw_fault;

  // Set wins over clear; a still-present source re-sets at once
  assign fault_input_latch_d = enabled_faults | (flag_clear ? 8'h00 : fault_input_latch_q);
  // A clear also retires the software fault, so it must not re-set the flag
  assign fault_flag_d = (|enabled_faults) || (sw_fault && !flag_clear) ||
                        (fault_flag_q && !flag_clear);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_input_latch_q <= reset_byte;
      fault_flag_q <= 1'b0;
    end else begin
      fault_input_latch_q <= fault_input_latch_d;
      fault_flag_q <= fault_flag_d;
    end
  end

  assign fault_irq = fault_flag_q && fault_irq_enable_q;

  // ****************************************************************
  // Pin override
  // ****************************************************************
  // Shutdown is held by the flag, or instantly by a present source
  assign fault_active = block_enable_q && (fault_flag_q || fault_now);
  logic [7:0] normal_out;
  logic [7:0] normal_oe_n;
  logic [7:0] override_output_channel;
  logic [7:0] override_oe_n;

  assign normal_out = {port_a_normal, port_b_normal, port_c_normal};
  assign normal_oe_n = {port_a_normal_oe_n, port_b_normal_oe_n, port_c_normal_oe_n};

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      wire forced = fault_active && pin_function_enable_q[i];
      assign override_output_channel[i] = forced ? pin_value_q[i] : normal_out[i];
      assign override_oe_n[i] = forced ? !pin_direction_q[i] : normal_oe_n[i];
    end
  endgenerate

  assign port_c_out = override_output_channel[3:0];
  assign port_c_oe_n = override_oe_n[3:0];
  assign port_b_out = override_output_channel[5:4];
  assign port_b_oe_n = override_oe_n[5:4];
  assign port_a_out = override_output_channel[7:6];
  assign port_a_oe_n = override_oe_n[7:6];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_fault_seen;
    block_enable_q && |(fault_input_channel & fault_input_enable_q);
  endsequence

  a_fault_sets_flag: assert property (@(posedge clock) disable iff (!nrst)
    s_fault_seen |=> fault_flag_q) else $error("fault did not set flag");
  a_latch_follows: assert property (@(posedge clock) disable iff (!nrst)
    s_fault_seen |=> ((fault_input_latch_q & $past(enabled_faults)) == $past(enabled_faults)))
    else $error("latch missed fault");
  a_disabled_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !block_enable_q |-> (override_oe_n == normal_oe_n) && (override_output_channel == normal_out))
    else $error("disabled block overrode pin");
  a_bypass_pin: assert property (@(posedge clock) disable iff (!nrst)
    !pin_function_enable_q[0] |-> port_c_out[0] == port_c_normal[0])
    else $error("bypass pin altered");
  a_force_now: assert property (@(posedge clock) disable iff (!nrst)
    (fault_now && block_enable_q && pin_function_enable_q[7] && pin_direction_q[7]) |->
    (port_a_out[1] == pin_value_q[7]) && !port_a_oe_n[1]) else $error("pin not forced");
  a_hiz_fault: assert property (@(posedge clock) disable iff (!nrst)
    (fault_active && pin_function_enable_q[4] && !pin_direction_q[4]) |-> port_b_oe_n[0])
    else $error("pin not released to high impedance");
  a_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
    fault_irq == (fault_flag_q && fault_irq_enable_q)) else $error("irq gating wrong");
  a_flag_holds: assert property (@(posedge clock) disable iff (!nrst)
    (fault_flag_q && !flag_clear) |=> fault_flag_q) else $error("flag dropped uncleared");
  a_swforce: assert property (@(posedge clock) disable iff (!nrst)
    (wr_cs && pwdata[bit_force_fault] && pwdata[bit_block_enable] && block_enable_q)
    |=> ##1 fault_flag_q)
    else $error("force fault ignored");

  // ****************************************************************
  // Clearing, release and register checks
  // ****************************************************************
  // Clear request while no enabled hardware source is present
  sequence s_flag_cleared;
    fault_flag_q && flag_clear && !(|enabled_faults);
  endsequence

  // Write to one configuration byte through lane 0
  sequence s_pin_value_write;
    wr_lane0 && hit(paddr, off_pin_value);
  endsequence

  sequence s_input_enable_write;
    wr_lane0 && hit(paddr, off_input_enable);
  endsequence

  a_clear_works: assert property (@(posedge clock) disable iff (!nrst)
    s_flag_cleared |=> !fault_flag_q)
    else $error("flag clear ignored");

  a_latch_clears: assert property (@(posedge clock) disable iff (!nrst)
    s_flag_cleared |=> (fault_input_latch_q == 8'h00))
    else $error("latch not cleared");

  a_latch_holds: assert property (@(posedge clock) disable iff (!nrst)
    !flag_clear |=>
    ((fault_input_latch_q & $past(fault_input_latch_q)) == $past(fault_input_latch_q)))
    else $error("latch bit lost");

  // A latch bit may only rise for a channel that was enabled and active
  a_only_enabled: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=>
    ((fault_input_latch_q & ~($past(fault_input_latch_q) | $past(enabled_faults))) == 8'h00))
    else $error("latch set by disabled input");

  a_irq_needs_flag: assert property (@(posedge clock) disable iff (!nrst)
    !fault_flag_q |-> !fault_irq)
    else $error("irq without flag");

  a_hold_while_flag: assert property (@(posedge clock) disable iff (!nrst)
    (block_enable_q && fault_flag_q && pin_function_enable_q[6] && pin_direction_q[6]) |->
    (port_a_out[0] == pin_value_q[6]) && !port_a_oe_n[0])
    else $error("pin released while flag set");

  a_release_after: assert property (@(posedge clock) disable iff (!nrst)
    (block_enable_q && !fault_flag_q && !fault_now) |->
    (override_output_channel == normal_out) && (override_oe_n == normal_oe_n))
    else $error("pin held after release");

  // Every driven pin under fault shows its preset value
  a_all_values: assert property (@(posedge clock) disable iff (!nrst)
    fault_active |->
    (((override_output_channel ^ pin_value_q) & pin_function_enable_q & pin_direction_q)
    == 8'h00))
    else $error("configured pin not forced");

  a_all_dirs: assert property (@(posedge clock) disable iff (!nrst)
    fault_active |->
    (((override_oe_n ^ ~pin_direction_q) & pin_function_enable_q) == 8'h00))
    else $error("configured pin direction wrong");

  a_bypass_all: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |->
    (((override_output_channel ^ normal_out) & ~pin_function_enable_q) == 8'h00) &&
    (((override_oe_n ^ normal_oe_n) & ~pin_function_enable_q) == 8'h00))
    else $error("bypass pin altered");

  a_drive_value: assert property (@(posedge clock) disable iff (!nrst)
    (fault_active && pin_function_enable_q[2] && pin_direction_q[2]) |->
    (port_c_out[2] == pin_value_q[2]) && !port_c_oe_n[2])
    else $error("driven level wrong");

  a_one_clock: assert property (@(posedge clock) disable iff (!nrst)
    (s_fault_seen && pin_function_enable_q[0] && pin_direction_q[0]) |->
    (port_c_out[0] == pin_value_q[0]) && !port_c_oe_n[0])
    else $error("shutdown delayed");

  // Asynchronous sources reach the channel two edges later
  a_sync_pin: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |-> (fault_input_channel[6] == $past(external_fault_pin, 2)))
    else $error("external pin path wrong");

  a_sync_debug: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |-> (fault_input_channel[7] == $past(debug_mode_active, 2)))
    else $error("debug path wrong");

  a_disabled_no_flag: assert property (@(posedge clock) disable iff (!nrst)
    (!block_enable_q && !fault_flag_q) |=> !fault_flag_q)
    else $error("disabled block raised flag");

  a_value_write: assert property (@(posedge clock) disable iff (!nrst)
    s_pin_value_write |=> (pin_value_q == $past(pwdata[7:0])))
    else $error("pin value write lost");

  a_enable_write: assert property (@(posedge clock) disable iff (!nrst)
    s_input_enable_write |=> (fault_input_enable_q == $past(pwdata[7:0])))
    else $error("input enable write lost");

  a_irq_en_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_cs |=> (fault_irq_enable_q == $past(pwdata[bit_fault_irq_enable])))
    else $error("irq enable write lost");

  a_read_upper: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |-> (prdata[31:8] == 24'h000000))
    else $error("read upper bits set");

endmodule

// >>> hw/fault_shutdown_pkg.sv
/*
  Constants for the fault detection and shutdown block: APB register
  offsets, bit positions of the control and status register, reset values.
  Assumes an APB slave with 32-bit data and byte-wide registers in the low bits.
*/
package fault_shutdown_pkg;

  localparam logic [7:0] off_control_status = 8'h00;
  localparam logic [7:0] off_input_enable = 8'h04;
  localparam logic [7:0] off_input_latch = 8'h08;
  localparam logic [7:0] off_pin_enable = 8'h0c;
  localparam logic [7:0] off_pin_direction = 8'h10;
  localparam logic [7:0] off_pin_value = 8'h14;

  localparam int bit_fault_flag = 7;
  localparam int bit_fault_irq_enable = 6;
  localparam int bit_block_enable = 5;
  localparam int bit_force_fault = 0;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam int sync_stages = 2;

endpackage

// >>> sim/fault_source_model.sv
/*
  Far side of the shutdown block: peripheral fault request lines and the
  timer outputs that normally own the controlled pins.
  Assumes the bench commands the fault levels; pin values change every cycle.
*/
`timescale 1ns/1ps
module fault_source_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] fault_req,
  output logic [7:0] fault_line,
  output logic [7:0] normal_out,
  output logic [7:0] normal_oe_n
);
  logic [7:0] cnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Timer pins change every cycle so a stuck override cannot hide
  assign normal_out = cnt_q ^ 8'h5a;
  assign normal_oe_n = {cnt_q[0], cnt_q[7:1]};
  assign fault_line = fault_req;
endmodule

// >>> sim/tb_fault_detect_shutdown.sv
/*
  Testbench of the fault shutdown block: APB tasks and directed sequences.
  Assumes zero wait state APB and the far side model beside the design.
*/
`timescale 1ns/1ps
module tb_fault_detect_shutdown;
  import fault_shutdown_pkg::*;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, fault_irq;
  logic [7:0] paddr, fr, fl, nv, noe, pe, pd, pv;
  logic [31:0] pwdata, prdata;
  logic [7:0] po, poe;
  int fails, compares, cyc;
  fault_source_model far (.clock(clock), .nrst(nrst), .fault_req(fr), .fault_line(fl),
    .normal_out(nv), .normal_oe_n(noe));
  fault_detect_shutdown dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keyboard_interrupt(fl[0]),
    .comparator0_interrupt(fl[1]), .comparator1_interrupt(fl[2]),
    .modulo_timer0_interrupt(fl[3]), .modulo_timer1_interrupt(fl[4]),
    .pulse_width_timer_ready(fl[5]), .external_fault_pin(fl[6]),
    .debug_mode_active(fl[7]), .port_c_normal(nv[3:0]), .port_c_normal_oe_n(noe[3:0]),
    .port_b_normal(nv[5:4]), .port_b_normal_oe_n(noe[5:4]), .port_a_normal(nv[7:6]),
    .port_a_normal_oe_n(noe[7:6]), .port_c_out(po[3:0]), .port_c_oe_n(poe[3:0]),
    .port_b_out(po[5:4]), .port_b_oe_n(poe[5:4]), .port_a_out(po[7:6]),
    .port_a_oe_n(poe[7:6]), .fault_irq(fault_irq));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task finish_test;
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      finish_test;
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check("register", r, {24'h000000, x});
    check("pslverr", e, {31'h0, a > off_pin_value});
  endtask
  // Samples the pins mid cycle; forced hi-z pins have no defined level
  task pins(input logic f);
    logic [7:0] m, k;
    @(negedge clock);
    m = f ? pe : 8'h00;
    k = ~(m & ~pd);
    check("pin_oe_n", poe, (m & ~pd) | (~m & noe));
    check("pin_out", po & k, ((m & pv) | (~m & nv)) & k);
    @(posedge clock);
  endtask
  initial begin
    {fails, compares, cyc} = 0;
    {psel, penable, pwrite, paddr, pwdata, fr} = '0;
    nrst = 1'b0;
    {pe, pd, pv} = {8'hff, 8'hef, 8'ha5};
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
    pins(1'b0);
    wr(off_input_enable, 8'h04);
    wr(off_pin_enable, pe);
    wr(off_pin_direction, pd);
    wr(off_pin_value, pv);
    wr(off_control_status, 8'h60);
    fr <= 8'h04;
    pins(1'b1);
    rd(off_control_status, 8'he0);
    rd(off_input_latch, 8'h04);
    check("irq", fault_irq, 1);
    wr(off_control_status, 8'h60);
    rd(off_control_status, 8'he0);
    fr <= 8'h00;
    pins(1'b1);
    rd(off_input_latch, 8'h04);
    wr(off_control_status, 8'h60);
    rd(off_control_status, 8'h60);
    rd(off_input_latch, 8'h00);
    check("irq", fault_irq, 0);
    pins(1'b0);
    fr <= 8'h01;
    pins(1'b0);
    rd(off_control_status, 8'h60);
    fr <= 8'h00;
    wr(off_control_status, 8'h21);
    pins(1'b1);
    rd(off_control_status, 8'ha0);
    check("irq", fault_irq, 0);
    wr(off_control_status, 8'h20);
    wr(off_control_status, 8'h01);
    fr <= 8'h04;
    pins(1'b0);
    rd(off_control_status, 8'h00);
    fr <= 8'h00;
    wr(off_control_status, 8'h20);
    for (int i = 0; i < 8; i++) begin
      wr(off_input_enable, 8'h01 << i);
      fr <= 8'h01 << i;
      repeat (3) @(posedge clock);
      rd(off_input_latch, 8'h01 << i);
      fr <= 8'h00;
      repeat (3) @(posedge clock);
      wr(off_control_status, 8'h20);
    end
    rd(off_input_latch, 8'h00);
    finish_test;
  end
endmodule
